/* pkg/cssm_pkg.sv */
// package of constants for the clock source and stop mode select block
package cssm_pkg;
    // ------------------------------------------------------------
    // register map (word addresses on the avalon slave)
    // ------------------------------------------------------------
    localparam logic [2:0] CSSM_ADDR_CLK_SEL = 3'h0;  // clock_select_control
    localparam logic [2:0] CSSM_ADDR_IRQ_EN = 3'h1;  // local interrupt enables
    localparam logic [2:0] CSSM_ADDR_STATUS = 3'h2;  // live status, read only
    localparam logic [2:0] CSSM_ADDR_MISC = 3'h3;  // oscillator enable, watchdog low select
    // ------------------------------------------------------------
    // clock_select_control field positions and reset value
    // ------------------------------------------------------------
    localparam int CSSM_BIT_PLL_SEL = 7;
    localparam int CSSM_BIT_PSEUDO_STOP_SELECT_SEL = 6;
    localparam int CSSM_BIT_WDOG_HI = 4;
    localparam int CSSM_BIT_PIT_PSEUDO_STOP_SELECT = 3;
    localparam int CSSM_BIT_WDOG_PSEUDO_STOP_SELECT = 2;
    localparam int CSSM_BIT_PIT_CSEL = 0;
    localparam logic [7:0] CSSM_CLK_SEL_RESET = 8'h80;
    localparam logic [7:0] CSSM_CLK_SEL_MASK = 8'hdd;
    // ------------------------------------------------------------
    // misc register fields
    // ------------------------------------------------------------
    localparam int CSSM_BIT_OSC_EN = 0;
    localparam int CSSM_BIT_WDOG_LO = 1;
    // ------------------------------------------------------------
    // interrupt enable positions, shared by enable and request vectors
    // ------------------------------------------------------------
    localparam int CSSM_NUM_IRQ = 5;
    localparam int CSSM_IRQ_TIMER = 0;
    localparam int CSSM_IRQ_LOCK = 1;
    localparam int CSSM_IRQ_OSC = 2;
    localparam int CSSM_IRQ_LVD = 3;
    localparam int CSSM_IRQ_API = 4;
    // ------------------------------------------------------------
    // clock source encodings and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSSM_SRC_IRC = 2'b00,
        CSSM_SRC_OSC = 2'b01,
        CSSM_SRC_ACLK = 2'b11
    } cssm_src_t;
    localparam int CSSM_BUS_DIV = 2;  // bus clock is half the source
    localparam int CSSM_CLK_MHZ = 100;
    localparam int CSSM_LOCK_DELAY_NS = 1000;  // oscillator qualify time after lock
    localparam int CSSM_LOCK_DELAY_CYC = (CSSM_LOCK_DELAY_NS * CSSM_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] CSSM_RDATA_UNMAPPED = 8'h00;
endpackage : cssm_pkg

/* core/cssm_osc_qual.sv */
// oscillator-up qualifier: raises the up flag after lock
`timescale 1ns/1ns
`default_nettype none
module cssm_osc_qual
    import cssm_pkg::*;
#(
    parameter int DELAY_CYC = CSSM_LOCK_DELAY_CYC
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic osc_en_in,
    input wire logic lock_in,
    input wire logic full_stop_in,
    output logic osc_up_out
);
    logic [15:0] cnt_q;

    // flag low while disabled or in full stop; set only after lock has held
    always_ff @(posedge mclk_in) begin
        if (reset_in || !osc_en_in || full_stop_in || !lock_in) begin
            cnt_q <= 16'h0000;
            osc_up_out <= 1'b0;
        end else if (cnt_q == 16'(DELAY_CYC)) begin
            osc_up_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : cssm_osc_qual
`default_nettype wire

/* core/cssm_src_div.sv */
// source clock enable divider: bus enable at half the source rate
`timescale 1ns/1ns
`default_nettype none
module cssm_src_div (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic src_tick_in,
    output logic bus_tick_out
);
    logic half_q;

    // every second source tick gives one bus tick
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            half_q <= 1'b0;
            bus_tick_out <= 1'b0;
        end else begin
            bus_tick_out <= src_tick_in && half_q;
            if (src_tick_in) begin
                half_q <= ~half_q;
            end
        end
    end
endmodule : cssm_src_div
`default_nettype wire

/* core/cssm_top.sv */
// clock source and stop mode select with avalon register slave
`timescale 1ns/1ns
`default_nettype none
module cssm_top
    import cssm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    // avalon-mm slave
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // clock ticks (one-cycle enables) and status
    input wire logic pll_tick_in,
    input wire logic osc_tick_in,
    input wire logic irc_tick_in,
    input wire logic aclk_tick_in,
    input wire logic pll_lock_in,
    input wire logic osc_lock_in,
    input wire logic stop_req_in,
    input wire logic global_mask_in,
    input wire logic [4:0] irq_flags_in,
    // outputs
    output logic sys_tick_out,
    output logic bus_tick_out,
    output logic osc_run_out,
    output logic osc_up_out,
    output logic pit_tick_out,
    output logic wdog_tick_out,
    output logic wdog_restart_out,
    output logic [4:0] irq_out
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] clk_sel_q;
    logic [4:0] irq_en_q;
    logic osc_en_q;
    logic wdog_lo_q;
    logic stop_q;
    logic ack_q;
    logic osc_up;
    logic bus_tick;
    logic full_stop_d;
    logic pseudo_stop;
    logic src_tick;
    logic wdog_src_tick;
    logic pit_run;
    logic wdog_run;
    logic wr_hit;
    logic [7:0] wdata;

    assign wdata = avs_writedata_in[7:0];
    // a write lands on the edge that shows waitrequest low, never earlier
    assign wr_hit = avs_write_in && ack_q;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait state: request accepted on the second edge, then released
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in || avs_write_in) && !ack_q;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_q);
        end
    end

    // read data captured together with the acknowledge
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !ack_q) begin
            unique case (avs_address_in)
                CSSM_ADDR_CLK_SEL: avs_readdata_out <= {24'h00_0000, clk_sel_q};
                CSSM_ADDR_IRQ_EN: avs_readdata_out <= {27'h000_0000, irq_en_q};
                CSSM_ADDR_STATUS: avs_readdata_out <= {27'h000_0000, pll_lock_in, stop_q,
                    pseudo_stop, osc_run_out, osc_up};
                CSSM_ADDR_MISC: avs_readdata_out <= {30'h0000_0000, wdog_lo_q, osc_en_q};
                default: avs_readdata_out <= {24'h00_0000, CSSM_RDATA_UNMAPPED};
            endcase
        end
    end

    // ------------------------------------------------------------
    // stop mode tracking
    // ------------------------------------------------------------
    // full stop begins when stop is requested with pseudo stop clear
    assign full_stop_d = stop_req_in && !clk_sel_q[CSSM_BIT_PSEUDO_STOP_SELECT_SEL];
    assign pseudo_stop = stop_q && clk_sel_q[CSSM_BIT_PSEUDO_STOP_SELECT_SEL];

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_req_in;
        end
    end

    // oscillator runs unless disabled or in full stop
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            osc_run_out <= 1'b0;
        end else begin
            osc_run_out <= osc_en_q && !(stop_req_in && !clk_sel_q[CSSM_BIT_PSEUDO_STOP_SELECT_SEL]);
        end
    end

    // ------------------------------------------------------------
    // clock select register
    // ------------------------------------------------------------
    // pll select is forced high by oscillator down or full stop entry;
    // the force wins over a software clear in the same cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            clk_sel_q <= CSSM_CLK_SEL_RESET;
        end else begin
            if (wr_hit && avs_address_in == CSSM_ADDR_CLK_SEL) begin
                clk_sel_q <= wdata & CSSM_CLK_SEL_MASK;
                if (!osc_up) begin
                    clk_sel_q[CSSM_BIT_PLL_SEL] <= 1'b1;
                end
            end
            if (!osc_up) begin
                clk_sel_q[CSSM_BIT_PLL_SEL] <= 1'b1;
            end
            if (full_stop_d && !stop_q) begin
                clk_sel_q[CSSM_BIT_PLL_SEL] <= 1'b1;
            end
        end
    end

    // other software bits; oscillator down leaves the watchdog low select alone
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            irq_en_q <= 5'h00;
            osc_en_q <= 1'b0;
            wdog_lo_q <= 1'b0;
        end else if (wr_hit) begin
            if (avs_address_in == CSSM_ADDR_IRQ_EN) begin
                irq_en_q <= wdata[4:0];
            end
            if (avs_address_in == CSSM_ADDR_MISC) begin
                osc_en_q <= wdata[CSSM_BIT_OSC_EN];
                wdog_lo_q <= wdata[CSSM_BIT_WDOG_LO];
            end
        end
    end

    // ------------------------------------------------------------
    // oscillator qualify and source mux
    // ------------------------------------------------------------
    cssm_osc_qual u_osc_qual (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .osc_en_in(osc_en_q),
        .lock_in(osc_lock_in),
        .full_stop_in(full_stop_d),
        .osc_up_out(osc_up)
    );

    // pll or oscillator; oscillator used only while up
    assign src_tick = clk_sel_q[CSSM_BIT_PLL_SEL] ? pll_tick_in
        : (osc_up && osc_tick_in);

    cssm_src_div u_src_div (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .src_tick_in(src_tick),
        .bus_tick_out(bus_tick)
    );

    // system clocks stop in any stop mode
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sys_tick_out <= 1'b0;
            bus_tick_out <= 1'b0;
            osc_up_out <= 1'b0;
        end else begin
            sys_tick_out <= src_tick && !stop_q;
            bus_tick_out <= bus_tick && !stop_q;
            osc_up_out <= osc_up;
        end
    end

    // ------------------------------------------------------------
    // periodic timer and watchdog clocks
    // ------------------------------------------------------------
    // timer keeps running in stop only in pseudo stop with both bits set
    assign pit_run = !stop_q || (pseudo_stop && clk_sel_q[CSSM_BIT_PIT_PSEUDO_STOP_SELECT]
        && clk_sel_q[CSSM_BIT_PIT_CSEL]);

    // high select picks aux clock; otherwise low select picks rc or oscillator
    assign wdog_src_tick = clk_sel_q[CSSM_BIT_WDOG_HI] ? aclk_tick_in
        : (wdog_lo_q ? osc_tick_in : irc_tick_in);

    // frozen, not reset, when stopped; pseudo stop needs the osc source
    assign wdog_run = !stop_q || (pseudo_stop && clk_sel_q[CSSM_BIT_WDOG_PSEUDO_STOP_SELECT]
        && !clk_sel_q[CSSM_BIT_WDOG_HI] && wdog_lo_q);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pit_tick_out <= 1'b0;
            wdog_tick_out <= 1'b0;
        end else begin
            pit_tick_out <= pit_run && (clk_sel_q[CSSM_BIT_PIT_CSEL] ? osc_tick_in
                : irc_tick_in);
            wdog_tick_out <= wdog_run && wdog_src_tick;
        end
    end

    // restart pulse on any change of high select; low select change
    // while high is set is deliberately silent
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            wdog_restart_out <= 1'b0;
        end else begin
            wdog_restart_out <= wr_hit && avs_address_in == CSSM_ADDR_CLK_SEL
                && (wdata[CSSM_BIT_WDOG_HI] != clk_sel_q[CSSM_BIT_WDOG_HI]);
        end
    end

    // ------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------
    // flags come from the event sources; masked locally and globally
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            irq_out <= 5'h00;
        end else begin
            irq_out <= global_mask_in ? 5'h00 : (irq_flags_in & irq_en_q);
        end
    end
endmodule : cssm_top
`default_nettype wire

/* test/cssm_assertions.sv */
// port checker for the clock source and stop mode select block
`timescale 1ns/1ns
`default_nettype none
module cssm_assertions
    import cssm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [2:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic pll_tick_in,
    input wire logic osc_tick_in,
    input wire logic irc_tick_in,
    input wire logic aclk_tick_in,
    input wire logic osc_lock_in,
    input wire logic stop_req_in,
    input wire logic global_mask_in,
    input wire logic [4:0] irq_flags_in,
    input wire logic sys_tick_out,
    input wire logic bus_tick_out,
    input wire logic osc_up_out,
    input wire logic pit_tick_out,
    input wire logic wdog_tick_out,
    input wire logic wdog_restart_out,
    input wire logic [4:0] irq_out
);
    // ----------------------------------------------------------------
    // single clock domain, so one default clocking and disable
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    sequence s_taken;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_one_ready;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    AST_BUS_ANSWER: assert property (s_taken |-> ##[0:2] s_one_ready)
        else $error("bus request not answered by one ready cycle");
    AST_IRQ_MASKED: assert property (global_mask_in |=> irq_out == 5'h00)
        else $error("interrupt request while globally masked");
    AST_IRQ_CAUSE: assert property (irq_out != 5'h00 |->
        (irq_out & ~$past(irq_flags_in)) == 5'h00 && !$past(global_mask_in))
        else $error("interrupt request without a raised flag");
    AST_OSC_UP_LOCK: assert property ($rose(osc_up_out) |-> $past(osc_lock_in))
        else $error("oscillator up flag rose without lock");
    AST_SYS_SOURCE: assert property (sys_tick_out |-> $past(pll_tick_in || osc_tick_in))
        else $error("system tick without a pll or oscillator tick");
    AST_STOP_GATE: assert property (stop_req_in [*3] |-> !sys_tick_out && !bus_tick_out)
        else $error("system clock running in stop");
    AST_PIT_SOURCE: assert property (pit_tick_out |-> $past(irc_tick_in || osc_tick_in))
        else $error("timer tick without its source tick");
    AST_WDOG_SOURCE: assert property (wdog_tick_out |->
        $past(aclk_tick_in || irc_tick_in || osc_tick_in))
        else $error("watchdog tick without a source tick");
    AST_RESTART_CAUSE: assert property (wdog_restart_out |->
        ($past(avs_write_in) && $past(avs_address_in) == CSSM_ADDR_CLK_SEL) ||
        ($past(avs_write_in, 2) && $past(avs_address_in, 2) == CSSM_ADDR_CLK_SEL))
        else $error("watchdog restart without a select write");
    AST_RESTART_PULSE: assert property (wdog_restart_out |=> !wdog_restart_out)
        else $error("watchdog restart longer than one cycle");
endmodule : cssm_assertions
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the clock source and stop mode select block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import cssm_pkg::*;
    localparam int TICKS = 20;  // 80 cycle window, one source tick per 4 cycles
    logic mclk_in = 1'b0, reset_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [2:0] avs_address_in = 3'h0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd_q;
    logic pll_tick_in = 1'b0, osc_tick_in = 1'b0, irc_tick_in = 1'b0, aclk_tick_in = 1'b0;
    logic pll_lock_in = 1'b0, osc_lock_in = 1'b0, stop_req_in = 1'b0, global_mask_in = 1'b0;
    logic avs_waitrequest_out, sys_tick_out, bus_tick_out, osc_run_out, osc_up_out;
    logic pit_tick_out, wdog_tick_out, wdog_restart_out, mk;
    logic [4:0] irq_flags_in = 5'h00, irq_out, en, fl;
    logic [3:0] src_on_q = 4'h0;
    logic [1:0] phase_q = 2'h0;
    logic [31:0] lfsr_q = 32'h6a61;
    int n_errors = 0, n_compared = 0, n_cycles = 0;
    int cnt [5] = '{default: 0};
    int got [5];

    cssm_top dut (.mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .pll_tick_in(pll_tick_in),
        .osc_tick_in(osc_tick_in), .irc_tick_in(irc_tick_in), .aclk_tick_in(aclk_tick_in),
        .pll_lock_in(pll_lock_in), .osc_lock_in(osc_lock_in), .stop_req_in(stop_req_in),
        .global_mask_in(global_mask_in), .irq_flags_in(irq_flags_in),
        .sys_tick_out(sys_tick_out), .bus_tick_out(bus_tick_out), .osc_run_out(osc_run_out),
        .osc_up_out(osc_up_out), .pit_tick_out(pit_tick_out), .wdog_tick_out(wdog_tick_out),
        .wdog_restart_out(wdog_restart_out), .irq_out(irq_out));

    always #5 mclk_in = ~mclk_in;
    // each source on its own phase, so a count tells which one got through
    always @(posedge mclk_in) begin
        phase_q <= phase_q + 2'h1;
        pll_tick_in <= src_on_q[0] && phase_q == 2'h0;
        osc_tick_in <= src_on_q[1] && phase_q == 2'h1;
        irc_tick_in <= src_on_q[2] && phase_q == 2'h2;
        aclk_tick_in <= src_on_q[3] && phase_q == 2'h3;
    end
    // pulse counters and hang guard
    always @(posedge mclk_in) begin
        cnt[0] <= cnt[0] + int'(sys_tick_out === 1'b1);
        cnt[1] <= cnt[1] + int'(bus_tick_out === 1'b1);
        cnt[2] <= cnt[2] + int'(pit_tick_out === 1'b1);
        cnt[3] <= cnt[3] + int'(wdog_tick_out === 1'b1);
        cnt[4] <= cnt[4] + int'(wdog_restart_out === 1'b1);
        n_cycles <= n_cycles + 1;
        if (n_cycles == 10000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // expectations, comparisons and bus cycles
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] exp_sel(input logic [7:0] w, input logic up);
        return (w & CSSM_CLK_SEL_MASK) | (up ? 8'h00 : 8'h80);
    endfunction : exp_sel
    function automatic logic [4:0] exp_irq(input logic [4:0] f, input logic [4:0] e, input logic m);
        return m ? 5'h00 : (f & e);
    endfunction : exp_irq
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_val
    // zero means frozen, so no slack there; else one tick for window edges
    task automatic check_cnt(input int g, input int e);
        n_compared++;
        if (g < e - int'(e > 0) || g > e + int'(e > 0)) begin
            n_errors++;
            $display("wrong value at %0t: count %0d expected %0d", $time, g, e);
        end
    endtask : check_cnt
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        rd_q = avs_readdata_out;
        if (n >= 50) begin
            n_errors++;
            $display("wrong value at %0t: no bus answer", $time);
        end
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge mclk_in);
    endtask : xfer
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        check_val(rd_q, {24'h0, e});
    endtask : rd_chk
    task automatic measure(input logic [3:0] on);
        int base [5];
        src_on_q <= on;
        repeat (8) @(posedge mclk_in);
        base = cnt;
        repeat (80) @(posedge mclk_in);
        foreach (got[i]) got[i] = cnt[i] - base[i];
    endtask : measure
    task automatic finish_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        rd_chk(CSSM_ADDR_CLK_SEL, CSSM_CLK_SEL_RESET);
        rd_chk(3'h5, CSSM_RDATA_UNMAPPED);
        rd_chk(CSSM_ADDR_IRQ_EN, 8'h00);
        // oscillator down: pll select stays, watchdog high select still taken
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h10);
        rd_chk(CSSM_ADDR_CLK_SEL, exp_sel(8'h10, 1'b0));
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h10);
        measure(4'b0001);
        check_cnt(got[0], TICKS);
        check_cnt(got[1], TICKS / CSSM_BUS_DIV);
        check_val(cnt[4], 1);
        xfer(1'b1, CSSM_ADDR_MISC, 8'h03);
        repeat (150) @(posedge mclk_in);
        check_val(osc_up_out, 1'b0);
        osc_lock_in <= 1'b1;
        repeat (CSSM_LOCK_DELAY_CYC - 5) @(posedge mclk_in);
        check_val(osc_up_out, 1'b0);
        repeat (15) @(posedge mclk_in);
        check_val(osc_up_out, 1'b1);
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h00);
        rd_chk(CSSM_ADDR_CLK_SEL, exp_sel(8'h00, 1'b1));
        measure(4'b0111);
        check_cnt(got[0], TICKS);
        check_cnt(got[1], TICKS / CSSM_BUS_DIV);
        check_cnt(got[2], TICKS);
        check_cnt(got[3], TICKS);
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h11);
        measure(4'b1100);
        check_cnt(got[2], 0);
        check_cnt(got[3], TICKS);
        xfer(1'b1, CSSM_ADDR_MISC, 8'h01);
        xfer(1'b1, CSSM_ADDR_MISC, 8'h03);
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h4d);
        // oscillator has been up far longer than its startup time here
        stop_req_in <= 1'b1;
        measure(4'b0010);
        check_cnt(got[2], TICKS);
        check_cnt(got[3], TICKS);
        check_val(osc_run_out, 1'b1);
        rd_chk(CSSM_ADDR_STATUS, 8'h0f);
        // four high select changes so far; low select writes stay silent
        check_val(cnt[4], 4);
        stop_req_in <= 1'b0;
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h41);
        stop_req_in <= 1'b1;
        measure(4'b0010);
        check_cnt(got[2], 0);
        check_cnt(got[3], 0);
        stop_req_in <= 1'b0;
        xfer(1'b1, CSSM_ADDR_MISC, 8'h02);
        repeat (4) @(posedge mclk_in);
        rd_chk(CSSM_ADDR_CLK_SEL, exp_sel(8'h41, 1'b0));
        rd_chk(CSSM_ADDR_MISC, 8'h02);
        xfer(1'b1, CSSM_ADDR_MISC, 8'h03);
        repeat (CSSM_LOCK_DELAY_CYC + 15) @(posedge mclk_in);
        xfer(1'b1, CSSM_ADDR_CLK_SEL, 8'h00);
        stop_req_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        check_val(osc_run_out, 1'b0);
        rd_chk(CSSM_ADDR_CLK_SEL, 8'h80);
        stop_req_in <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            en = (i < 2) ? 5'h1f : lfsr_q[4:0];
            fl = (i < 2) ? 5'h1f : lfsr_q[12:8];
            mk = (i == 1) || (i > 1 && lfsr_q[16]);
            xfer(1'b1, CSSM_ADDR_IRQ_EN, {3'h0, en});
            rd_chk(CSSM_ADDR_IRQ_EN, {3'h0, en});
            irq_flags_in <= fl;
            global_mask_in <= mk;
            pll_lock_in <= lfsr_q[20];
            repeat (3) @(posedge mclk_in);
            check_val(irq_out, exp_irq(fl, en, mk));
            xfer(1'b0, CSSM_ADDR_STATUS, 8'h00);
            check_val(rd_q[4], lfsr_q[20]);
        end
        finish_test();
    end
endmodule : tb_top
bind cssm_top cssm_assertions u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .pll_tick_in(pll_tick_in),
    .osc_tick_in(osc_tick_in), .irc_tick_in(irc_tick_in), .aclk_tick_in(aclk_tick_in),
    .osc_lock_in(osc_lock_in), .stop_req_in(stop_req_in), .global_mask_in(global_mask_in),
    .irq_flags_in(irq_flags_in), .sys_tick_out(sys_tick_out), .bus_tick_out(bus_tick_out),
    .osc_up_out(osc_up_out), .pit_tick_out(pit_tick_out), .wdog_tick_out(wdog_tick_out),
    .wdog_restart_out(wdog_restart_out), .irq_out(irq_out));
`default_nettype wire
